// ==== logic/sme_defines.vh ====
// Constants for the status and message exchange block: bit positions, sizes, codes.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef SME_DEFINES_VH
`define SME_DEFINES_VH
// Event status register bit positions.
`define SME_ESR_OPC     0
`define SME_ESR_QYE     2
`define SME_ESR_DDE     3
`define SME_ESR_EXE     4
`define SME_ESR_CME     5
// Status byte bit positions.
`define SME_STB_MAV     4
`define SME_STB_ESB     5
`define SME_STB_RQS     6
// Default input buffer depth in characters and its index width.
`define SME_IBUF_DEPTH  128
`define SME_IBUF_AW     7
// Default output queue depth and index width.
`define SME_OQ_DEPTH    16
`define SME_OQ_AW       4
// Error queue depth and index width.
`define SME_EQ_DEPTH    8
`define SME_EQ_AW       3
// Error numbers appended to the error queue.
`define SME_ERRNO_CME   8'h65
`define SME_ERRNO_EXE   8'h66
`define SME_ERRNO_DDE   8'h67
`define SME_ERRNO_QYE   8'h68
// Character codes recognised by the parser.
`define SME_CH_STAR     8'h2a
`define SME_CH_QMARK    8'h3f
`define SME_CH_LF       8'h0a
`define SME_CH_T        8'h54
`define SME_CH_LOW_A    8'h61
`define SME_CH_SPACE    8'h20
`define SME_CH_TILDE    8'h7e
`endif

// ==== logic/sme_exchange.v ====
// Message exchange and status reporting core: input buffer, parser, sequential execution,
// response formatting into the output queue, event status and service request logic.
// Assumes the commander, the function logic and the error sources sit on ref_clk,
// except the protocol-fault pulse and word serial trigger pulse, which are synchronised here.
`timescale 1ns/1ns
`include "sme_defines.vh"

// Overview of operation
// - Execute commands one at a time, never overlapped.
// - Internal or self-test fault sets event bit 3.
// - Top-priority error each cycle appends its number to queue.
// - Word serial trigger and *TRG both start measurement.
// - Query responses go into the output queue.
// - Message available bit high while queue holds bytes.
// - Message available bit clears when queue empties.
// - Data-out-ready follows output queue occupancy.
// - Protocol breakage sets query error, bit 2.
// - Request service on programming error or enabled event.
// - Bad syntax sets command error, bit 5.
// - Unexecutable parsed message sets execution error, bit 4.
// - 128-character input FIFO; full drops data-in-ready.
// - Request service state appears on status bit 6.
module sme_exchange #(
  parameter IBUF_DEPTH = `SME_IBUF_DEPTH,
  parameter IBUF_AW    = `SME_IBUF_AW,
  parameter OQ_DEPTH   = `SME_OQ_DEPTH,
  parameter OQ_AW      = `SME_OQ_AW
) (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_data,
  output wire        data_in_ready,
  input  wire        ws_trigger_in,
  input  wire        resp_rd,
  output reg  [7:0]  resp_data,
  output wire        data_out_ready,
  output reg         exec_valid,
  output reg  [7:0]  exec_code,
  output reg         exec_is_query,
  input  wire        exec_done,
  input  wire        exec_illegal,
  input  wire        resp_valid,
  input  wire [7:0]  resp_byte,
  output reg         meas_trigger,
  input  wire        dev_fault,
  input  wire        proto_fault_in,
  input  wire [7:0]  ese_mask,
  input  wire        esb_enable,
  input  wire        esr_read,
  output reg  [7:0]  esr_value,
  output wire [7:0]  status_byte,
  output wire        srq,
  input  wire        errq_rd,
  output wire [7:0]  errq_data,
  output wire        errq_empty
);
  // Parser and execution states, one-hot.
  localparam [4:0] ST_IDLE = 5'h01;   // Waiting for a character.
  localparam [4:0] ST_HDR  = 5'h02;   // Inside a message, collecting a header.
  localparam [4:0] ST_EXEC = 5'h04;   // A message is in the function logic.
  localparam [4:0] ST_SKIP = 5'h08;   // Discarding a bad message up to its terminator.
  localparam [4:0] ST_TRIG = 5'h10;   // Issuing a measurement trigger.

  reg  [4:0] state_r;               // Current state.
  reg  [4:0] state_nxt;             // Next state.
  reg  [7:0] code_r;                // Header character being built.
  reg  [7:0] code_nxt;
  reg        query_r;               // Header carried a query mark.
  reg        query_nxt;
  reg        star_r;                // Header began with a star.
  reg        star_nxt;
  reg  [7:0] esr_r;                 // Latched event status flags.
  reg  [1:0] wst_sync_r;            // Word serial trigger synchroniser.
  reg        wst_prev_r;            // Previous synchronised trigger level.
  reg  [1:0] pf_sync_r;             // Protocol fault synchroniser.
  reg        pf_prev_r;             // Previous synchronised fault level.
  reg        prog_err_r;            // A programming error wants service.
  reg        wst_pend_r;            // A word serial trigger waits for the buffer.
  reg        wst_lf_r;              // The injected T still needs its line feed.
  reg        ib_rd;                 // Parser consumes one character.
  reg        cme_ev;                // Command error event this cycle.
  reg        exe_ev;                // Execution error event this cycle.
  reg        ib_wr;                 // Input buffer write strobe.
  reg  [7:0] ib_wdata;              // Input buffer write data.
  reg        eq_wr;                 // Error queue write strobe.
  reg  [7:0] eq_wdata;              // Error number to append.
  wire [7:0] ib_data;               // Character at the head of the input buffer.
  wire       ib_full;
  wire       ib_empty;
  wire       oq_full;
  wire       oq_empty;
  wire [7:0] oq_head;
  wire       eq_full;
  wire       wst_pulse;             // Rising edge of synchronised trigger.
  wire       qye_ev;                // Query error event this cycle.
  wire       dde_ev;                // Device dependent error event this cycle.
  wire [7:0] ev_set;                // All event bits to set this cycle.
  wire       esb;                   // Summary of enabled events.
  wire       rqs;                   // Request service state.

  // True for a printable header character.
  function is_hdr_char;
    input [7:0] c;
    begin
      is_hdr_char = (c > `SME_CH_SPACE) && (c < `SME_CH_TILDE);
    end
  endfunction

  // Folds a character to upper case so headers compare without case.
  function [7:0] upcase;
    input [7:0] c;
    begin
      upcase = (c >= `SME_CH_LOW_A) ? (c - `SME_CH_SPACE) : c;
    end
  endfunction

  // Input buffer; its full flag is the data-in-ready indication.
  sme_fifo #(.DEPTH(IBUF_DEPTH), .AW(IBUF_AW)) u_ibuf (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .wr_en   (ib_wr),
    .wr_data (ib_wdata),
    .rd_en   (ib_rd),
    .rd_data (ib_data),
    .full    (ib_full),
    .empty   (ib_empty)
  );
  assign data_in_ready = !ib_full;

  // Output queue holding formatted responses until the commander reads them.
  sme_fifo #(.DEPTH(OQ_DEPTH), .AW(OQ_AW)) u_oq (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .wr_en   (resp_valid && (state_r == ST_EXEC) && query_r),
    .wr_data (resp_byte),
    .rd_en   (resp_rd),
    .rd_data (oq_head),
    .full    (oq_full),
    .empty   (oq_empty)
  );
  assign data_out_ready = !oq_empty;

  // Error queue; a full queue drops new numbers rather than overwrite old ones.
  sme_fifo #(.DEPTH(`SME_EQ_DEPTH), .AW(`SME_EQ_AW)) u_eq (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .wr_en   (eq_wr),
    .wr_data (eq_wdata),
    .rd_en   (errq_rd),
    .rd_data (errq_data),
    .full    (eq_full),
    .empty   (errq_empty)
  );

  // The word serial trigger is injected as a T-LF message so it is parsed like *TRG.
  // The command stream has priority; a pending trigger waits for an idle, non-full cycle.
  always @* begin
    ib_wr    = 1'b0;
    ib_wdata = cmd_data;
    if (cmd_valid && !ib_full) begin
      ib_wr = 1'b1;
    end else if (wst_pend_r && !ib_full) begin
      ib_wr    = 1'b1;
      ib_wdata = `SME_CH_T;
    end else if (wst_lf_r && !ib_full) begin
      ib_wr    = 1'b1;
      ib_wdata = `SME_CH_LF;
    end
  end

  // Synchronisers and edge detectors for the two asynchronous event pins.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wst_sync_r <= 2'h0;
      wst_prev_r <= 1'b0;
      pf_sync_r  <= 2'h0;
      pf_prev_r  <= 1'b0;
    end else begin
      wst_sync_r <= {wst_sync_r[0], ws_trigger_in};
      wst_prev_r <= wst_sync_r[1];
      pf_sync_r  <= {pf_sync_r[0], proto_fault_in};
      pf_prev_r  <= pf_sync_r[1];
    end
  end
  assign wst_pulse = wst_sync_r[1] && !wst_prev_r;
  assign qye_ev    = pf_sync_r[1] && !pf_prev_r;
  assign dde_ev    = dev_fault;

  // Pending word serial trigger: a T and then a line feed are written.
  // Injected triggers skip the star, so the parser takes a bare T as a trigger too.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wst_pend_r <= 1'b0;
    end else if (wst_pulse) begin
      wst_pend_r <= 1'b1;
    end else if (!cmd_valid && !ib_full) begin
      wst_pend_r <= 1'b0;
    end
  end

  // Without the line feed the parser would swallow the next message while skipping.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wst_lf_r <= 1'b0;
    end else if (!cmd_valid && !ib_full) begin
      wst_lf_r <= wst_pend_r;
    end
  end

  // Parser and execution control. Only one message is ever in the function logic.
  always @* begin
    state_nxt = state_r;
    code_nxt  = code_r;
    query_nxt = query_r;
    star_nxt  = star_r;
    ib_rd     = 1'b0;
    cme_ev    = 1'b0;
    exe_ev    = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (!ib_empty) begin
          ib_rd     = 1'b1;
          query_nxt = 1'b0;
          star_nxt  = (ib_data == `SME_CH_STAR);
          code_nxt  = upcase(ib_data);
          if (ib_data == `SME_CH_LF || ib_data == `SME_CH_SPACE) begin
            state_nxt = ST_IDLE;
          end else if (upcase(ib_data) == `SME_CH_T) begin
            state_nxt = ST_TRIG;
          end else if (is_hdr_char(ib_data)) begin
            state_nxt = ST_HDR;
          end else begin
            cme_ev    = 1'b1;
            state_nxt = ST_SKIP;
          end
        end
      end
      ST_HDR: begin
        if (!ib_empty) begin
          ib_rd = 1'b1;
          if (ib_data == `SME_CH_LF) begin
            state_nxt = ST_EXEC;
          end else if (ib_data == `SME_CH_QMARK) begin
            query_nxt = 1'b1;
          end else if (star_r && (code_r == `SME_CH_STAR) && upcase(ib_data) == `SME_CH_T) begin
            state_nxt = ST_TRIG;
          end else if (is_hdr_char(ib_data) && !query_r) begin
            code_nxt = upcase(ib_data);
          end else begin
            cme_ev    = 1'b1;
            state_nxt = ST_SKIP;
          end
        end
      end
      ST_EXEC: begin
        // New characters stay in the buffer until this message has finished.
        if (exec_done) begin
          exe_ev    = exec_illegal;
          state_nxt = ST_IDLE;
        end
      end
      ST_SKIP: begin
        if (!ib_empty) begin
          ib_rd = 1'b1;
          if (ib_data == `SME_CH_LF) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_TRIG: begin
        state_nxt = ST_SKIP;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State and header registers, plus the one-cycle trigger and execute outputs.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r       <= ST_IDLE;
      code_r        <= 8'h00;
      query_r       <= 1'b0;
      star_r        <= 1'b0;
      exec_valid    <= 1'b0;
      exec_code     <= 8'h00;
      exec_is_query <= 1'b0;
      meas_trigger  <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      code_r        <= code_nxt;
      query_r       <= query_nxt;
      star_r        <= star_nxt;
      exec_valid    <= (state_r != ST_EXEC) && (state_nxt == ST_EXEC);
      exec_code     <= code_nxt;
      exec_is_query <= query_nxt;
      meas_trigger  <= (state_nxt == ST_TRIG) && (state_r != ST_TRIG);
    end
  end

  // Response head is registered so the data output comes from a flip-flop.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_data <= 8'h00;
    end else if (!oq_empty) begin
      resp_data <= oq_head;
    end
  end

  // Error numbers: one per cycle, fixed priority when several errors coincide.
  // The trade-off is that a simultaneous second error loses its number, not its flag.
  always @* begin
    eq_wr    = !eq_full;
    eq_wdata = `SME_ERRNO_CME;
    if (cme_ev) begin
      eq_wdata = `SME_ERRNO_CME;
    end else if (exe_ev) begin
      eq_wdata = `SME_ERRNO_EXE;
    end else if (dde_ev) begin
      eq_wdata = `SME_ERRNO_DDE;
    end else if (qye_ev) begin
      eq_wdata = `SME_ERRNO_QYE;
    end else begin
      eq_wr = 1'b0;
    end
  end

  // Event status flags. A new event wins over the clear by a read in the same cycle.
  assign ev_set = ({7'h00, qye_ev} << `SME_ESR_QYE) |
                  ({7'h00, dde_ev} << `SME_ESR_DDE) |
                  ({7'h00, exe_ev} << `SME_ESR_EXE) |
                  ({7'h00, cme_ev} << `SME_ESR_CME);
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      esr_r     <= 8'h00;
      esr_value <= 8'h00;
    end else begin
      esr_value <= esr_r;
      if (esr_read) begin
        esr_r <= ev_set;
      end else begin
        esr_r <= esr_r | ev_set;
      end
    end
  end

  // Programming errors (command and query errors) request service until read out.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_err_r <= 1'b0;
    end else if (cme_ev || qye_ev) begin
      prog_err_r <= 1'b1;
    end else if (esr_read) begin
      prog_err_r <= 1'b0;
    end
  end

  // Status byte assembly and the request service output.
  assign esb = |(esr_r & ese_mask);
  assign rqs = (esb && esb_enable) || prog_err_r;
  assign srq = rqs;
  assign status_byte = ({7'h00, !oq_empty} << `SME_STB_MAV) |
                       ({7'h00, esb} << `SME_STB_ESB) |
                       ({7'h00, rqs} << `SME_STB_RQS);
endmodule // sme_exchange

// ==== logic/sme_fifo.v ====
// Byte FIFO built from flip-flops, used for the input buffer, the output queue and the error queue.
// Assumes a single clock; the writer honours full and the reader honours empty.
`timescale 1ns/1ns
module sme_fifo #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         ref_clk,
  input  wire         arst_n,
  input  wire         wr_en,
  input  wire [7:0]   wr_data,
  input  wire         rd_en,
  output wire [7:0]   rd_data,
  output wire         full,
  output wire         empty
);
  reg  [7:0]  mem_r [0:DEPTH-1];   // Storage cells.
  reg  [AW:0] cnt_r;               // Bytes held.
  reg  [AW-1:0] wp_r;              // Write index.
  reg  [AW-1:0] rp_r;              // Read index.
  wire        do_wr;
  wire        do_rd;

  // A write into a full store or a read from an empty one is dropped.
  assign do_wr   = wr_en && !full;
  assign do_rd   = rd_en && !empty;
  assign full    = (cnt_r == DEPTH[AW:0]);
  assign empty   = (cnt_r == {(AW+1){1'b0}});
  assign rd_data = mem_r[rp_r];

  // Pointers wrap at DEPTH so the depth need not be a power of two.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= {(AW+1){1'b0}};
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
    end else begin
      if (do_wr) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Data cells need no reset; the empty flag guards any stale content.
  always @(posedge ref_clk) begin
    if (do_wr) begin
      mem_r[wp_r] <= wr_data;
    end
  end
endmodule // sme_fifo

// ==== verif/sme_exchange_properties.sv ====
// Checker for the message exchange block: timing relations between its ports.
// Assumes one clock, ref_clk, and the asynchronous active-low reset arst_n.
`timescale 1ns/1ns
module sme_exchange_properties (
  input wire       ref_clk,
  input wire       arst_n,
  input wire       exec_valid,
  input wire       exec_done,
  input wire       resp_valid,
  input wire       data_out_ready,
  input wire [7:0] status_byte,
  input wire       srq,
  input wire       dev_fault,
  input wire       proto_fault_in,
  input wire       esr_read,
  input wire [7:0] esr_value,
  input wire [7:0] ese_mask,
  input wire       esb_enable,
  input wire       errq_empty,
  input wire       meas_trigger
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  reg busy_r;  // High while one message is with the function logic.
  // Tracks the outstanding message so that an overlapping start is visible.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) busy_r <= 1'b0;
    else if (exec_valid) busy_r <= 1'b1;
    else if (exec_done) busy_r <= 1'b0;
  end
  a_no_overlap: assert property (exec_valid |-> !busy_r)
    else $error("message started while another runs");
  a_exec_spacing: assert property (busy_r && exec_done |=> !exec_valid [*2])
    else $error("message started too soon after completion");
  a_dde_flag: assert property (dev_fault |-> ##2 esr_value[3])
    else $error("fault did not set event bit 3");
  a_errno_queued: assert property (dev_fault |=> !errq_empty)
    else $error("fault left error queue empty");
  a_qye_flag: assert property ($rose(proto_fault_in) |-> ##[3:5] esr_value[2])
    else $error("protocol fault did not set event bit 2");
  a_mav_set: assert property (resp_valid && busy_r |=> data_out_ready && status_byte[4])
    else $error("response byte not reported available");
  a_mav_clear: assert property (!data_out_ready && !resp_valid |=> !data_out_ready)
    else $error("empty queue reported available");
  a_mav_match: assert property (status_byte[4] == data_out_ready)
    else $error("available bit and data-out-ready differ");
  a_rqs_bit: assert property (status_byte[6] == srq)
    else $error("status bit 6 differs from service request");
  a_srq_event: assert property (esb_enable && (esr_value & ese_mask) != 8'h00 && !$past(esr_read) |-> srq)
    else $error("enabled event gave no service request");
  a_flags_latched: assert property (!$past(esr_read)
    |=> (esr_value & $past(esr_value) & 8'h3c) == ($past(esr_value) & 8'h3c))
    else $error("event flag lost without a read");
  a_meas_pulse: assert property (meas_trigger |=> !meas_trigger)
    else $error("measurement start longer than one cycle");
endmodule // sme_exchange_properties

bind sme_exchange sme_exchange_properties sme_exchange_properties_i (.ref_clk(ref_clk), .arst_n(arst_n),
  .exec_valid(exec_valid), .exec_done(exec_done), .resp_valid(resp_valid), .data_out_ready(data_out_ready),
  .status_byte(status_byte), .srq(srq), .dev_fault(dev_fault), .proto_fault_in(proto_fault_in),
  .esr_read(esr_read), .esr_value(esr_value), .ese_mask(ese_mask), .esb_enable(esb_enable),
  .errq_empty(errq_empty), .meas_trigger(meas_trigger));

// ==== verif/sme_func_model.sv ====
// Model of the function logic behind the block: runs each message for a set time.
// Assumes the block pulses exec_valid once per message and then waits for exec_done.
`timescale 1ns/1ns
module sme_func_model (
  input  wire       ref_clk,
  input  wire       arst_n,
  input  wire       exec_valid,
  input  wire       exec_is_query,
  input  wire [7:0] exec_delay,
  input  wire       illegal_en,
  output reg        exec_done,
  output reg        exec_illegal,
  output reg        resp_valid,
  output reg  [7:0] resp_byte
);
  reg [7:0] cnt_r;  // Cycles left for the running message; zero when idle.
  reg       qry_r;  // The running message expects a response.
  // Execution takes exec_delay cycles, at least 3, so quick and slow answers both occur.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r        <= 8'h00;
      qry_r        <= 1'b0;
      exec_done    <= 1'b0;
      exec_illegal <= 1'b0;
      resp_valid   <= 1'b0;
      resp_byte    <= 8'h00;
    end else begin
      exec_done    <= 1'b0;
      exec_illegal <= 1'b0;
      resp_valid   <= 1'b0;
      resp_byte    <= ~resp_byte;  // Idle data keeps changing so a stale byte never looks valid.
      if (exec_valid) begin
        cnt_r <= exec_delay;
        qry_r <= exec_is_query;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
        // A query answers with a digit and a line feed before it completes.
        if (qry_r && (cnt_r == 8'h03 || cnt_r == 8'h02)) begin
          resp_valid <= 1'b1;
          resp_byte  <= (cnt_r == 8'h03) ? 8'h31 : 8'h0a;
        end
        if (cnt_r == 8'h01) begin
          exec_done    <= 1'b1;
          exec_illegal <= illegal_en;
        end
      end
    end
  end
endmodule // sme_func_model

// ==== verif/status_message_exchange_test.sv ====
// Self-checking bench for the message exchange block and a function logic model.
// Assumes both run on ref_clk at 100 MHz and share the reset arst_n.
`timescale 1ns/1ns
module status_message_exchange_test;
  reg        ref_clk = 1'b0;
  reg        arst_n = 1'b0;
  reg        cmd_valid = 1'b0;
  reg  [7:0] cmd_data = 8'h00;
  reg        ws_trigger_in = 1'b0;
  reg        resp_rd = 1'b0;
  reg        dev_fault = 1'b0;
  reg        proto_fault_in = 1'b0;
  reg  [7:0] ese_mask = 8'h00;
  reg        esb_enable = 1'b0;
  reg        esr_read = 1'b0;
  reg        errq_rd = 1'b0;
  reg  [7:0] exec_delay = 8'h04;  // Model execution time in cycles.
  reg        illegal_en = 1'b0;  // Model rejects the messages it runs.
  wire       data_in_ready, data_out_ready, exec_valid, exec_is_query, exec_done, exec_illegal;
  wire       resp_valid, meas_trigger, srq, errq_empty;
  wire [7:0] resp_data, exec_code, resp_byte, esr_value, status_byte, errq_data;
  integer    failures = 0;
  integer    checks_done = 0;
  integer    n_meas = 0;  // Measurement starts seen.
  integer    e_meas = 0;  // Measurement starts expected.
  integer    n, seed_v;
  reg        last_q = 1'b0;  // Query flag of the last message passed to the function logic.
  reg  [7:0] exp_esr = 8'h00;  // Expected event status.
  reg  [7:0] q_out[$];  // Expected output queue.
  reg  [7:0] q_err[$];  // Expected error queue.
  string     bad;
  always #5 ref_clk = ~ref_clk;
  sme_exchange sme_exchange_i (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .data_in_ready(data_in_ready), .ws_trigger_in(ws_trigger_in), .resp_rd(resp_rd), .resp_data(resp_data),
    .data_out_ready(data_out_ready), .exec_valid(exec_valid), .exec_code(exec_code), .exec_is_query(exec_is_query),
    .exec_done(exec_done), .exec_illegal(exec_illegal), .resp_valid(resp_valid), .resp_byte(resp_byte),
    .meas_trigger(meas_trigger), .dev_fault(dev_fault), .proto_fault_in(proto_fault_in), .ese_mask(ese_mask),
    .esb_enable(esb_enable), .esr_read(esr_read), .esr_value(esr_value), .status_byte(status_byte), .srq(srq),
    .errq_rd(errq_rd), .errq_data(errq_data), .errq_empty(errq_empty));
  sme_func_model sme_func_model_i (.ref_clk(ref_clk), .arst_n(arst_n), .exec_valid(exec_valid),
    .exec_is_query(exec_is_query), .exec_delay(exec_delay), .illegal_en(illegal_en), .exec_done(exec_done),
    .exec_illegal(exec_illegal), .resp_valid(resp_valid), .resp_byte(resp_byte));
  // Pulses are counted here because a one-cycle output is easily missed by the main sequence.
  always @(posedge ref_clk) begin
    if (meas_trigger === 1'b1) n_meas = n_meas + 1;
    if (exec_valid === 1'b1) last_q = exec_is_query;
  end
  task tick; begin
    @(posedge ref_clk);
    #1;
  end endtask
  task chk_b(input [7:0] exp, input [7:0] got); begin
    checks_done = checks_done + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  end endtask
  task chk_f(input exp, input got); begin
    chk_b({7'h00, exp}, {7'h00, got});
  end endtask
  // Bytes go back to back; the strobe drops only while the buffer is full.
  task send_str(input string s); integer i; begin
    for (i = 0; i < s.len(); i = i + 1) begin
      while (data_in_ready !== 1'b1) begin
        cmd_valid = 1'b0;
        tick;
      end
      cmd_valid = 1'b1;
      cmd_data = s[i];
      tick;
    end
    cmd_valid = 1'b0;
  end endtask
  // Reads the output queue; resp_data trails the head by a cycle, hence the two waits.
  task drain_out; begin
    n = 0;
    while (data_out_ready !== 1'b1 && n < 400) begin
      tick;
      n = n + 1;
    end
    repeat (3) tick;
    chk_f(1'b1, status_byte[4]);
    while (q_out.size() > 0) begin
      chk_b(q_out.pop_front(), resp_data);
      resp_rd = 1'b1;
      tick;
      resp_rd = 1'b0;
      repeat (2) tick;
    end
    chk_f(1'b0, data_out_ready);
    chk_f(1'b0, status_byte[4]);
  end endtask
  // Compares event status, service request and error queue, then clears them.
  task check_errs(input exp_srq); begin
    repeat (8) tick;
    chk_b(exp_esr, esr_value);
    chk_f(exp_srq, srq);
    while (q_err.size() > 0) begin
      chk_f(1'b0, errq_empty);
      chk_b(q_err.pop_front(), errq_data);
      errq_rd = 1'b1;
      tick;
      errq_rd = 1'b0;
      tick;
    end
    chk_f(1'b1, errq_empty);
    esr_read = 1'b1;
    tick;
    esr_read = 1'b0;
    exp_esr = 8'h00;
    repeat (2) tick;
    chk_b(exp_esr, esr_value);
    chk_f(1'b0, srq);
  end endtask
  task check_meas; begin
    repeat (40) tick;
    chk_b(e_meas[7:0], n_meas[7:0]);
  end endtask
  task stop_test; begin
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  // Watchdog: the sequence needs well under 10000 cycles.
  initial begin
    #100000;
    failures = failures + 1;
    stop_test;
  end
  initial begin
    seed_v = $urandom(59410);  // Its bits pick the random flags and the mask below.
    repeat (3) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    chk_f(1'b1, data_in_ready);
    chk_b(8'h00, status_byte);
    errq_rd = seed_v[11];  // A pop of the empty queue must leave it empty.
    tick;
    errq_rd = 1'b0;
    chk_f(1'b1, errq_empty);
    // A query runs and its response is read back.
    exec_delay = $urandom_range(3, 9);
    illegal_en = seed_v[9];
    send_str("*IDN?\n");
    q_out.push_back(8'h31);
    q_out.push_back(8'h0a);
    drain_out;
    chk_f(1'b1, last_q);
    exp_esr[4] = illegal_en;
    if (illegal_en) q_err.push_back(8'h66);
    illegal_en = 1'b0;
    check_errs(1'b0);
    // Both trigger messages start one measurement each; the parser runs them itself.
    send_str("*TRG\n");
    e_meas = e_meas + 1;
    check_meas;
    chk_f(1'b1, last_q);
    ws_trigger_in = 1'b1;
    repeat (4) tick;
    ws_trigger_in = 1'b0;
    e_meas = e_meas + 1;
    check_meas;
    // A control character is a command error; service is requested even masked.
    bad = "?\n";
    bad.putc(0, $urandom_range(1, 9));
    esb_enable = seed_v[8];
    send_str(bad);
    exp_esr[5] = 1'b1;
    q_err.push_back(8'h65);
    check_errs(1'b1);
    // A rejected message with its event masked raises no request.
    esb_enable = 1'b1;
    ese_mask = seed_v[7:0] & 8'hef;
    illegal_en = 1'b1;
    send_str("*RST\n");
    repeat (20) tick;
    illegal_en = 1'b0;
    exp_esr[4] = 1'b1;
    q_err.push_back(8'h66);
    check_errs(1'b0);
    // An enabled fault requests service; with the summary disabled it does not.
    ese_mask = seed_v[7:0] | 8'h08;
    dev_fault = 1'b1;
    tick;
    dev_fault = 1'b0;
    exp_esr[3] = 1'b1;
    q_err.push_back(8'h67);
    check_errs(1'b1);
    esb_enable = 1'b0;
    dev_fault = 1'b1;
    tick;
    dev_fault = 1'b0;
    exp_esr[3] = 1'b1;
    q_err.push_back(8'h67);
    check_errs(1'b0);
    proto_fault_in = 1'b1;
    repeat (4) tick;
    proto_fault_in = 1'b0;
    exp_esr[2] = 1'b1;
    q_err.push_back(8'h68);
    check_errs(1'b1);
    // A slow query holds the next message back while the buffer fills.
    exec_delay = 8'hfa;
    send_str("*IDN?\n");
    tick;
    n = 0;
    cmd_data = 8'h42;
    while (data_in_ready === 1'b1 && n < 200) begin
      cmd_valid = 1'b1;
      tick;
      n = n + 1;
    end
    cmd_valid = 1'b0;
    chk_f(1'b1, n >= 128 && n < 140);
    send_str("\n");
    q_out.push_back(8'h31);
    q_out.push_back(8'h0a);
    drain_out;
    stop_test;
  end
endmodule // status_message_exchange_test
